//--- hw/srpc_defines.svh
// Timing counts and reset values for the sensor reset and power-down control
`ifndef SRPC_DEFINES_SVH
`define SRPC_DEFINES_SVH
`define SRPC_PULLUP_RESET_VAL 1'b1
`define SRPC_LASER_OFF 1'b1
`define SRPC_SYNC_STAGES 2
`define SRPC_PINS_IDLE 5'h05
`endif

//--- hw/srpc_pkg.sv
// Types for the sensor reset and power-down control
package srpc_pkg;
    typedef enum logic [1:0] {
        SRPC_UNRESET,
        SRPC_IN_RESET,
        SRPC_ACTIVE,
        SRPC_LOW_POWER
    } srpc_state_type;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic chip_select_low;
        logic reset;
        logic powerdown_request_low;
    } srpc_pins_type;
endpackage : srpc_pkg

//--- hw/srpc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
`default_nettype none
module srpc_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] rst_val_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;

    // First stage feeds only the second
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            stage1_r <= rst_val_in;
            sync_out <= rst_val_in;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule : srpc_sync
`default_nettype wire

//--- hw/srpc_ctl.sv
// Reset and low-power sequencing and pin control for the motion sensor
//
// Notes on behaviour
// - No self-reset; leave reset only after pulse
// - Reset input high holds device in reset
// - Power-down input ignored while reset held
// - Laser enable low output high during reset
// - Power-down low enters, high leaves low-power
// - Low-power stops oscillator, registers keep values
// - Outputs low or high-Z in low-power, except laser enable low, held high
`timescale 1ns/1ns
`default_nettype none
`include "srpc_defines.svh"
module srpc_ctl
    import srpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Pins from the microcontroller
    input wire srpc_pins_type pins_in,
    // Core requests while active
    input wire logic core_laser_on_in,
    input wire logic core_laser_drive_in,
    input wire logic core_pullup_set_in,
    input wire logic core_pullup_clr_in,
    input wire logic core_miso_in,
    // Serial inputs passed to the core
    output logic serial_sclk_out,
    output logic serial_mosi_out,
    output logic serial_enable_out,
    // Pin drives
    output logic laser_enable_low_out,
    output logic laser_drive_output_out,
    output logic laser_drive_output_oe_low_out,
    output logic pullup_enable_out,
    output logic miso_out,
    output logic miso_oe_low_out,
    // Clocking and status
    output logic osc_run_out,
    output logic core_reset_out,
    output logic low_power_state_out,
    output logic in_reset_out
);
    srpc_pins_type pins_sync;
    srpc_state_type state_r;
    srpc_state_type state_nxt;
    logic pullup_r;
    logic pullup_nxt;

    // Reset-side states: before the first pulse and while held
    function automatic logic srpc_held_reset(input srpc_state_type st);
        srpc_held_reset = (st == SRPC_UNRESET) || (st == SRPC_IN_RESET);
    endfunction : srpc_held_reset

    // Only the active state hands the pins to the core
    function automatic logic srpc_is_active(input srpc_state_type st);
        srpc_is_active = (st == SRPC_ACTIVE);
    endfunction : srpc_is_active

    // Pins are asynchronous; idle levels after reset avoid false requests
    srpc_sync #(
        .WIDTH($bits(srpc_pins_type))
    ) u_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(pins_in),
        .rst_val_in(`SRPC_PINS_IDLE),
        .sync_out(pins_sync)
    );

    // Decoded conditions
    wire rst_pin = pins_sync.reset;
    wire pd_req = ~pins_sync.powerdown_request_low;
    wire cs_act = ~pins_sync.chip_select_low;
    wire st_active = srpc_is_active(state_r);
    wire st_rst = (state_r == SRPC_IN_RESET);

    // Next-state decode shared by every pin drive except the data output enable
    wire nxt_act = srpc_is_active(state_nxt);
    wire nxt_low_power = (state_nxt == SRPC_LOW_POWER);
    wire nxt_in_reset = (state_nxt == SRPC_IN_RESET);
    wire nxt_held = srpc_held_reset(state_nxt);

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SRPC_UNRESET: begin
                if (rst_pin) state_nxt = SRPC_IN_RESET;
            end
            SRPC_IN_RESET: begin
                if (!rst_pin) state_nxt = SRPC_ACTIVE;
            end
            SRPC_ACTIVE: begin
                if (rst_pin) state_nxt = SRPC_IN_RESET;
                else if (pd_req) state_nxt = SRPC_LOW_POWER;
            end
            SRPC_LOW_POWER: begin
                if (rst_pin) state_nxt = SRPC_IN_RESET;
                else if (!pd_req) state_nxt = SRPC_ACTIVE;
            end
        endcase
    end

    // Pull-up setting: default on after reset, held over low-power
    always_comb begin
        pullup_nxt = pullup_r;
        if (st_rst) pullup_nxt = `SRPC_PULLUP_RESET_VAL;
        else if (st_active && core_pullup_set_in) pullup_nxt = 1'b1;
        else if (st_active && core_pullup_clr_in) pullup_nxt = 1'b0;
    end

    // State and pull-up registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_r <= SRPC_UNRESET;
            pullup_r <= `SRPC_PULLUP_RESET_VAL;
        end else begin
            state_r <= state_nxt;
            pullup_r <= pullup_nxt;
        end
    end

    // Serial inputs pass only while active, otherwise held low
    wire sclk_nxt = nxt_act & pins_sync.sclk;
    wire mosi_nxt = nxt_act & pins_sync.mosi;
    wire sel_nxt = nxt_act & cs_act;

    // Laser kept off and its drive released unless active
    wire laser_en_low_nxt = nxt_act ? ~core_laser_on_in : `SRPC_LASER_OFF;
    wire laser_drv_nxt = nxt_act & core_laser_on_in;
    wire laser_oe_low_nxt = ~(nxt_act & core_laser_drive_in);

    // Pull-ups follow the kept setting, off outside active
    wire pullup_en_nxt = nxt_act & pullup_nxt;

    // Data forced low outside active; enable follows select
    wire miso_nxt = nxt_act & core_miso_in;
    wire miso_oe_low_nxt = ~cs_act;

    // Serial clock and data pass-through
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            serial_sclk_out <= 1'b0;
            serial_mosi_out <= 1'b0;
        end else begin
            serial_sclk_out <= sclk_nxt;
            serial_mosi_out <= mosi_nxt;
        end
    end

    // Serial select towards the core
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            serial_enable_out <= 1'b0;
        end else begin
            serial_enable_out <= sel_nxt;
        end
    end

    // Laser enable, off in reset and low-power
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            laser_enable_low_out <= `SRPC_LASER_OFF;
        end else begin
            laser_enable_low_out <= laser_en_low_nxt;
        end
    end

    // Laser drive pin and its output enable
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            laser_drive_output_out <= 1'b0;
            laser_drive_output_oe_low_out <= 1'b1;
        end else begin
            laser_drive_output_out <= laser_drv_nxt;
            laser_drive_output_oe_low_out <= laser_oe_low_nxt;
        end
    end

    // Serial pull-up enable
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pullup_enable_out <= 1'b0;
        end else begin
            pullup_enable_out <= pullup_en_nxt;
        end
    end

    // Serial data out and its output enable
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            miso_out <= 1'b0;
            miso_oe_low_out <= 1'b1;
        end else begin
            miso_out <= miso_nxt;
            miso_oe_low_out <= miso_oe_low_nxt;
        end
    end

    // Oscillator run and low-power flag
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            osc_run_out <= 1'b1;
            low_power_state_out <= 1'b0;
        end else begin
            osc_run_out <= ~nxt_low_power;
            low_power_state_out <= nxt_low_power;
        end
    end

    // Reset status towards the core
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            core_reset_out <= 1'b1;
            in_reset_out <= 1'b0;
        end else begin
            core_reset_out <= nxt_held;
            in_reset_out <= nxt_in_reset;
        end
    end
endmodule : srpc_ctl
`default_nettype wire

//--- testbench/srpc_props.sv
// Checker of reset and low-power pin behaviour
`timescale 1ns/1ns
`default_nettype none
module srpc_props
    import srpc_pkg::*;
(
    // Watched ports
    input wire logic mclk_in, sys_rst_in, serial_sclk_out, serial_mosi_out,
    input wire logic serial_enable_out, laser_enable_low_out, pullup_enable_out,
    input wire logic laser_drive_output_oe_low_out, miso_out, osc_run_out,
    input wire logic core_reset_out, low_power_state_out, in_reset_out,
    input wire srpc_pins_type pins_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_reset_taken: assert property ($rose(pins_in.reset) |-> ##[1:4] in_reset_out)
        else $error("reset late");
    a_pd_ignored: assert property (pins_in.reset [*4] |-> !low_power_state_out)
        else $error("pd in reset");
    a_no_self: assert property ($fell(core_reset_out) |-> $past(in_reset_out))
        else $error("self reset");
    a_reset_outs: assert property (in_reset_out |-> laser_enable_low_out)
        else $error("laser in reset");
    a_wake_bound: assert property ($rose(pins_in.powerdown_request_low) && low_power_state_out
        |-> ##[1:4] !low_power_state_out)
        else $error("wake late");
    a_osc_stop: assert property (low_power_state_out |-> !osc_run_out)
        else $error("osc runs");
    a_lp_outs: assert property (low_power_state_out |-> laser_enable_low_out &&
        laser_drive_output_oe_low_out && !miso_out)
        else $error("lp outputs");
    a_serial_gate: assert property (in_reset_out || low_power_state_out |-> !serial_sclk_out
        && !serial_mosi_out && !serial_enable_out && !pullup_enable_out)
        else $error("serial open");
    a_pullup_on: assert property ($fell(in_reset_out) |-> pullup_enable_out)
        else $error("pullup off");
    // Main scenarios
    cover property ($rose(in_reset_out));
    cover property ($fell(in_reset_out));
    cover property ($fell(low_power_state_out));
endmodule : srpc_props
bind srpc_ctl srpc_props props (.*);
`default_nettype wire

//--- testbench/srpc_mcu.sv
// Microcontroller model driving the sensor pins
`timescale 1ns/1ns
`default_nettype none
module srpc_mcu
    import srpc_pkg::*;
(
    // Clock and pins
    input wire logic mclk_in,
    output var srpc_pins_type pins_out
);
    // Idle: reset low, select and power-down high
    initial pins_out = 5'h05;
    // Pins change just after an edge
    task drive(input srpc_pins_type v);
        @(posedge mclk_in);
        #1 pins_out = v;
    endtask : drive
endmodule : srpc_mcu
`default_nettype wire

//--- testbench/srpc_ctl_tb_top.sv
// Bench for reset and low-power sequencing
`timescale 1ns/1ns
`default_nettype none
module srpc_ctl_tb_top import srpc_pkg::*;;
    logic mclk_in = 0, sys_rst_in = 1, core_laser_on_in = 1, core_laser_drive_in = 1;
    logic core_pullup_set_in = 0, core_pullup_clr_in = 0, core_miso_in = 1;
    logic serial_sclk_out, serial_mosi_out, serial_enable_out, laser_enable_low_out;
    logic laser_drive_output_out, laser_drive_output_oe_low_out, pullup_enable_out;
    logic miso_out, miso_oe_low_out, osc_run_out, core_reset_out, low_power_state_out;
    logic in_reset_out;
    srpc_pins_type pins_in;
    int fail_count = 0, n_tests = 0;
    // Clock and instances
    always #20 mclk_in = ~mclk_in;
    srpc_ctl dut (.*);
    srpc_mcu mcu (.mclk_in(mclk_in), .pins_out(pins_in));
    task chk(input string n, input logic s, input logic e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, s);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge mclk_in);
        #2;
    endtask : step
    // Pulse, select low and serial lines busy
    task s_reset;
        mcu.drive(5'h1A);
        step(4);
        chk("in_reset", in_reset_out, 1'b1);
        chk("lp", low_power_state_out, 1'b0);
        chk("laser", laser_enable_low_out, 1'b1);
        chk("pullup", pullup_enable_out, 1'b0);
        chk("sclk", serial_sclk_out, 1'b0);
        chk("mosi", serial_mosi_out, 1'b0);
        chk("laser_oe", laser_drive_output_oe_low_out, 1'b1);
        mcu.drive(5'h19);
        step(4);
        chk("core_reset", core_reset_out, 1'b0);
        chk("pullup", pullup_enable_out, 1'b1);
        chk("sclk", serial_sclk_out, 1'b1);
        chk("laser", laser_enable_low_out, 1'b0);
        chk("in_reset", in_reset_out, 1'b0);
        chk("laser_oe", laser_drive_output_oe_low_out, 1'b0);
        chk("laser_drv", laser_drive_output_out, 1'b1);
        chk("miso", miso_out, 1'b1);
        chk("enable", serial_enable_out, 1'b1);
    endtask : s_reset
    // Pull-ups cleared, sleep, wake
    task s_power;
        @(posedge mclk_in);
        #1 core_pullup_clr_in = 1;
        @(posedge mclk_in);
        #1 core_pullup_clr_in = 0;
        mcu.drive(5'h18);
        step(4);
        chk("lp", low_power_state_out, 1'b1);
        chk("osc", osc_run_out, 1'b0);
        chk("miso", miso_out, 1'b0);
        chk("miso_oe", miso_oe_low_out, 1'b0);
        chk("serial", serial_enable_out, 1'b0);
        chk("laser", laser_enable_low_out, 1'b1);
        chk("laser_drv", laser_drive_output_out, 1'b0);
        chk("laser_oe", laser_drive_output_oe_low_out, 1'b1);
        mcu.drive(5'h19);
        step(4);
        chk("lp", low_power_state_out, 1'b0);
        chk("osc", osc_run_out, 1'b1);
        chk("pullup", pullup_enable_out, 1'b0);
        chk("miso", miso_out, 1'b1);
    endtask : s_power
    task summarize;
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // Reset, then no exit without a pulse
    initial begin
        repeat (20) @(posedge mclk_in);
        #1 sys_rst_in = 0;
        step(30);
        chk("core_reset", core_reset_out, 1'b1);
        s_reset();
        s_power();
        summarize();
    end
endmodule : srpc_ctl_tb_top
`default_nettype wire
